// >>> logic/oaf_operand_address_former.sv
`timescale 1ns/1ps
// Contract
// - A relative branch fetches its signed 8-bit displacement from the byte right after the opcode.
// - A taken branch adds the sign-extended displacement to the program counter and continues there.
// - Immediate mode takes the operand from the bytes after the opcode with no address computation.
// - A 16-bit immediate has its high byte right after the opcode and its low byte next.
// - Direct mode carries only the low eight address bits, confining the operand to page 0x0000-0x00FF.
// - The direct address is the implied upper byte 0x00 joined to the instruction's 8-bit address.
// - The no-offset indexed address is the index pair; its post-increment form is for compare-branch and move only.
// - Short-offset indexed mode adds an unsigned 8-bit offset to the index pair.
// - Short-offset indexed with post-increment exists only for compare-and-branch-if-equal.
// - Long-offset indexed mode adds a 16-bit offset from the instruction to the index pair.
// - Stack modes add an 8-bit or a 16-bit offset to the stack pointer.
// - Opcode A7 adds its sign-extended byte to the stack pointer, keeps the flags and takes 2 bus cycles.
// - Opcode AF adds its sign-extended byte to the index pair and keeps the flags.
// - Opcode 24 is relative, branches only when carry is 0 and takes 3 bus cycles.
// - Every formed address is a 16-bit value in one linear 64-Kbyte space.
module oaf_operand_address_former (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [3:0] mode,
  input wire logic is_compare_branch,
  input wire logic is_move,
  input wire logic branch_cond,
  input wire logic carry_flag,
  input wire logic [15:0] pc_in,
  input wire logic [15:0] hx_in,
  input wire logic [15:0] sp_in,
  input wire logic [7:0] mem_rdata,
  output logic busy,
  output logic mem_rd,
  output logic [15:0] mem_addr,
  output logic [15:0] ea,
  output logic [15:0] operand,
  output logic [15:0] pc_out,
  output logic pc_wr,
  output logic [15:0] hx_out,
  output logic hx_wr,
  output logic [15:0] sp_out,
  output logic sp_wr,
  output logic illegal,
  output logic done
);

  oaf_pkg::oaf_state_t state_reg;
  oaf_pkg::oaf_state_t state_next;
  oaf_pkg::oaf_mode_t mode_reg;
  oaf_pkg::oaf_mode_t mode_sel;
  logic add_sp_reg, add_ix_reg, cond_reg, compare_branch_if_equal_instruction_reg, move_reg;
  logic [1:0] nbytes_reg, nbytes_sel;
  logic [15:0] ptr_reg, op_addr_reg, hx_reg, sp_reg;
  logic [7:0] first_reg;
  logic fetching, fin, bad_post;
  logic [7:0] byte_hi, byte_lo;
  logic [15:0] word, sext, ptr_after, target;

  function automatic logic [1:0] operand_bytes(input oaf_pkg::oaf_mode_t m);
    unique case (m)
      oaf_pkg::OAF_INDEXED_NO_OFFSET_MODE, oaf_pkg::OAF_INDEXED_POST_INCREMENT_MODE: operand_bytes = 2'h0;
      oaf_pkg::OAF_IMMEDIATE_WORD_MODE, oaf_pkg::OAF_INDEXED_LONG_OFFSET_MODE,
      oaf_pkg::OAF_STACK_LONG_OFFSET_MODE: operand_bytes = 2'h2;
      default: operand_bytes = 2'h1;
    endcase
  endfunction

  // Three opcodes fix their own mode; others take the decoder's mode
  always_comb begin
    if (opcode == oaf_pkg::OPC_ADD_TO_STACK_POINTER || opcode == oaf_pkg::OPC_ADD_TO_INDEX) begin
      mode_sel = oaf_pkg::OAF_IMMEDIATE_MODE;
    end else if (opcode == oaf_pkg::OPC_BRANCH_IF_CARRY_CLEAR) begin
      mode_sel = oaf_pkg::OAF_RELATIVE_MODE;
    end else begin
      mode_sel = oaf_pkg::oaf_mode_t'(mode);
    end
    nbytes_sel = operand_bytes(mode_sel);
  end

  assign busy = (state_reg != oaf_pkg::OAF_ST_IDLE);
  assign fetching = (state_reg == oaf_pkg::OAF_ST_FETCH_FIRST) || (state_reg == oaf_pkg::OAF_ST_FETCH_SECOND);
  assign mem_rd = fetching;
  assign mem_addr = ptr_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      oaf_pkg::OAF_ST_IDLE: begin
        if (start) begin
          state_next = (nbytes_sel == 2'h0) ? oaf_pkg::OAF_ST_RESOLVE : oaf_pkg::OAF_ST_FETCH_FIRST;
        end
      end
      oaf_pkg::OAF_ST_FETCH_FIRST: begin
        if (nbytes_reg == 2'h2) begin
          state_next = oaf_pkg::OAF_ST_FETCH_SECOND;
        end else if (mode_reg == oaf_pkg::OAF_RELATIVE_MODE) begin
          state_next = oaf_pkg::OAF_ST_RESOLVE;
        end else begin
          state_next = oaf_pkg::OAF_ST_IDLE;
        end
      end
      oaf_pkg::OAF_ST_FETCH_SECOND: state_next = oaf_pkg::OAF_ST_IDLE;
      oaf_pkg::OAF_ST_RESOLVE: state_next = oaf_pkg::OAF_ST_IDLE;
      default: state_next = oaf_pkg::OAF_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= oaf_pkg::OAF_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Instruction context captured when start is taken
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= oaf_pkg::OAF_RELATIVE_MODE;
      nbytes_reg <= 2'h0;
      add_sp_reg <= 1'b0;
      add_ix_reg <= 1'b0;
      cond_reg <= 1'b0;
      compare_branch_if_equal_instruction_reg <= 1'b0;
      move_reg <= 1'b0;
      op_addr_reg <= oaf_pkg::ADDR_RESET;
      hx_reg <= oaf_pkg::ADDR_RESET;
      sp_reg <= oaf_pkg::ADDR_RESET;
    end else if (state_reg == oaf_pkg::OAF_ST_IDLE && start) begin
      mode_reg <= mode_sel;
      nbytes_reg <= nbytes_sel;
      add_sp_reg <= (opcode == oaf_pkg::OPC_ADD_TO_STACK_POINTER);
      add_ix_reg <= (opcode == oaf_pkg::OPC_ADD_TO_INDEX);
      cond_reg <= (opcode == oaf_pkg::OPC_BRANCH_IF_CARRY_CLEAR) ? ~carry_flag : branch_cond;
      compare_branch_if_equal_instruction_reg <= is_compare_branch;
      move_reg <= is_move;
      op_addr_reg <= pc_in;
      hx_reg <= hx_in;
      sp_reg <= sp_in;
    end
  end

  // Fetch pointer walks the operand bytes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ptr_reg <= oaf_pkg::ADDR_RESET;
      first_reg <= oaf_pkg::BYTE_RESET;
    end else if (state_reg == oaf_pkg::OAF_ST_IDLE && start) begin
      ptr_reg <= pc_in;
    end else if (fetching) begin
      ptr_reg <= ptr_reg + oaf_pkg::POST_INCREMENT_STEP;
      if (state_reg == oaf_pkg::OAF_ST_FETCH_FIRST) begin
        first_reg <= mem_rdata;
      end
    end
  end

  assign fin = (state_reg == oaf_pkg::OAF_ST_FETCH_FIRST && nbytes_reg == 2'h1
                && mode_reg != oaf_pkg::OAF_RELATIVE_MODE)
               || state_reg == oaf_pkg::OAF_ST_FETCH_SECOND || state_reg == oaf_pkg::OAF_ST_RESOLVE;

  assign byte_hi = (state_reg == oaf_pkg::OAF_ST_FETCH_SECOND) ? first_reg : 8'h00;
  assign byte_lo = (state_reg == oaf_pkg::OAF_ST_RESOLVE) ? first_reg : mem_rdata;
  assign word = {byte_hi, byte_lo};
  assign sext = {{8{byte_lo[7]}}, byte_lo};
  assign ptr_after = fetching ? ptr_reg + oaf_pkg::POST_INCREMENT_STEP : ptr_reg;
  assign target = ptr_after + sext;
  assign bad_post = (mode_reg == oaf_pkg::OAF_INDEXED_POST_INCREMENT_MODE && !(compare_branch_if_equal_instruction_reg || move_reg))
                    || (mode_reg == oaf_pkg::OAF_INDEXED_SHORT_OFFSET_POST_INCREMENT_MODE && !compare_branch_if_equal_instruction_reg);

  // Results; flags are never touched by this block
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ea <= oaf_pkg::ADDR_RESET;
      operand <= oaf_pkg::ADDR_RESET;
      pc_out <= oaf_pkg::ADDR_RESET;
      hx_out <= oaf_pkg::ADDR_RESET;
      sp_out <= oaf_pkg::ADDR_RESET;
      pc_wr <= 1'b0;
      hx_wr <= 1'b0;
      sp_wr <= 1'b0;
      illegal <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= fin;
      pc_wr <= fin;
      hx_wr <= 1'b0;
      sp_wr <= 1'b0;
      illegal <= fin && bad_post;
      if (fin) begin
        pc_out <= (mode_reg == oaf_pkg::OAF_RELATIVE_MODE && cond_reg) ? target : ptr_after;
        operand <= word;
        hx_out <= hx_reg;
        sp_out <= sp_reg;
        unique case (mode_reg)
          oaf_pkg::OAF_RELATIVE_MODE: ea <= target;
          oaf_pkg::OAF_IMMEDIATE_MODE, oaf_pkg::OAF_IMMEDIATE_WORD_MODE: ea <= op_addr_reg;
          oaf_pkg::OAF_DIRECT_MODE: ea <= {oaf_pkg::DIRECT_PAGE_HIGH, byte_lo};
          oaf_pkg::OAF_INDEXED_NO_OFFSET_MODE, oaf_pkg::OAF_INDEXED_POST_INCREMENT_MODE: ea <= hx_reg;
          oaf_pkg::OAF_INDEXED_SHORT_OFFSET_MODE, oaf_pkg::OAF_INDEXED_SHORT_OFFSET_POST_INCREMENT_MODE:
            ea <= hx_reg + {8'h00, byte_lo};
          oaf_pkg::OAF_INDEXED_LONG_OFFSET_MODE: ea <= hx_reg + word;
          oaf_pkg::OAF_STACK_SHORT_OFFSET_MODE: ea <= sp_reg + {8'h00, byte_lo};
          oaf_pkg::OAF_STACK_LONG_OFFSET_MODE: ea <= sp_reg + word;
          default: ea <= op_addr_reg;
        endcase
        if (!bad_post && (mode_reg == oaf_pkg::OAF_INDEXED_POST_INCREMENT_MODE
            || mode_reg == oaf_pkg::OAF_INDEXED_SHORT_OFFSET_POST_INCREMENT_MODE)) begin
          hx_out <= hx_reg + oaf_pkg::POST_INCREMENT_STEP;
          hx_wr <= 1'b1;
        end
        if (add_sp_reg) begin
          sp_out <= sp_reg + sext;
          sp_wr <= 1'b1;
        end
        if (add_ix_reg) begin
          hx_out <= hx_reg + sext;
          hx_wr <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_take_opcode(logic [7:0] code);
    !busy && start && opcode == code;
  endsequence

  property p_rel_fetch;
    !busy && start && opcode == oaf_pkg::OPC_BRANCH_IF_CARRY_CLEAR |=> mem_rd && mem_addr == $past(pc_in);
  endproperty
  a_rel_fetch: assert property (p_rel_fetch) else $error("displacement not fetched after opcode");
  property p_branch_taken;
    state_reg == oaf_pkg::OAF_ST_RESOLVE && mode_reg == oaf_pkg::OAF_RELATIVE_MODE && cond_reg
      |=> pc_wr && pc_out == $past(ptr_reg) + {{8{$past(first_reg[7])}}, $past(first_reg)};
  endproperty
  a_branch_taken: assert property (p_branch_taken) else $error("taken branch target wrong");
  property p_branch_not_taken;
    state_reg == oaf_pkg::OAF_ST_RESOLVE && mode_reg == oaf_pkg::OAF_RELATIVE_MODE && !cond_reg
      |=> pc_wr && pc_out == $past(ptr_reg);
  endproperty
  a_branch_not_taken: assert property (p_branch_not_taken) else $error("untaken branch moved pc");
  property p_imm_word;
    state_reg == oaf_pkg::OAF_ST_FETCH_SECOND && mode_reg == oaf_pkg::OAF_IMMEDIATE_WORD_MODE
      |=> operand == {$past(first_reg), $past(mem_rdata)} && !hx_wr && !sp_wr;
  endproperty
  a_imm_word: assert property (p_imm_word) else $error("immediate word byte order wrong");
  property p_direct;
    fin && mode_reg == oaf_pkg::OAF_DIRECT_MODE |=> ea[15:8] == 8'h00 && ea[7:0] == $past(mem_rdata);
  endproperty
  a_direct: assert property (p_direct) else $error("direct address not on page zero");
  property p_short_index;
    fin && mode_reg == oaf_pkg::OAF_INDEXED_SHORT_OFFSET_MODE |=> ea == $past(hx_reg) + {8'h00, $past(mem_rdata)};
  endproperty
  a_short_index: assert property (p_short_index) else $error("short indexed address wrong");
  property p_stack_short;
    fin && mode_reg == oaf_pkg::OAF_STACK_SHORT_OFFSET_MODE |=> ea == $past(sp_reg) + {8'h00, $past(mem_rdata)};
  endproperty
  a_stack_short: assert property (p_stack_short) else $error("stack short address wrong");
  property p_post_only_compare_branch_if_equal_instruction;
    fin && mode_reg == oaf_pkg::OAF_INDEXED_SHORT_OFFSET_POST_INCREMENT_MODE && !compare_branch_if_equal_instruction_reg |=> illegal && !hx_wr;
  endproperty
  a_post_only_compare_branch_if_equal_instruction: assert property (p_post_only_compare_branch_if_equal_instruction) else $error("post-increment allowed wrongly");
  property p_add_sp_cycles;
    s_take_opcode(oaf_pkg::OPC_ADD_TO_STACK_POINTER) |-> ##1 (mem_rd && !done) ##1 (done && sp_wr && !hx_wr);
  endproperty
  a_add_sp_cycles: assert property (p_add_sp_cycles) else $error("stack add timing wrong");
  property p_add_ix;
    s_take_opcode(oaf_pkg::OPC_ADD_TO_INDEX) ##1 1'b1
      |=> hx_wr && hx_out == $past(hx_reg) + {{8{$past(mem_rdata[7])}}, $past(mem_rdata)};
  endproperty
  a_add_ix: assert property (p_add_ix) else $error("index add wrong");
  property p_bcc_cycles;
    s_take_opcode(oaf_pkg::OPC_BRANCH_IF_CARRY_CLEAR) |-> ##1 mem_rd ##1 (!mem_rd && !done) ##1 done;
  endproperty
  a_bcc_cycles: assert property (p_bcc_cycles) else $error("carry branch timing wrong");

endmodule // oaf_operand_address_former

// >>> logic/oaf_pkg.sv
package oaf_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Opcodes resolved inside the block
  localparam logic [7:0] OPC_ADD_TO_STACK_POINTER = 8'hA7;
  localparam logic [7:0] OPC_ADD_TO_INDEX = 8'hAF;
  localparam logic [7:0] OPC_BRANCH_IF_CARRY_CLEAR = 8'h24;

  // Implied upper byte of a direct-page address
  localparam logic [7:0] DIRECT_PAGE_HIGH = 8'h00;

  // Values after reset, and the post-increment step
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] POST_INCREMENT_STEP = 16'h0001;

  // Bus cycles, counting the opcode cycle in which start is taken
  localparam int ADD_TO_STACK_POINTER_BUS_CYCLES = 2;
  localparam int BRANCH_BUS_CYCLES = 3;

  typedef enum logic [3:0] {
    OAF_RELATIVE_MODE = 4'h0,
    OAF_IMMEDIATE_MODE = 4'h1,
    OAF_IMMEDIATE_WORD_MODE = 4'h2,
    OAF_DIRECT_MODE = 4'h3,
    OAF_INDEXED_NO_OFFSET_MODE = 4'h4,
    OAF_INDEXED_POST_INCREMENT_MODE = 4'h5,
    OAF_INDEXED_SHORT_OFFSET_MODE = 4'h6,
    OAF_INDEXED_SHORT_OFFSET_POST_INCREMENT_MODE = 4'h7,
    OAF_INDEXED_LONG_OFFSET_MODE = 4'h8,
    OAF_STACK_SHORT_OFFSET_MODE = 4'h9,
    OAF_STACK_LONG_OFFSET_MODE = 4'hA
  } oaf_mode_t;

  typedef enum logic [3:0] {
    OAF_ST_IDLE = 4'h1,
    OAF_ST_FETCH_FIRST = 4'h2,
    OAF_ST_FETCH_SECOND = 4'h4,
    OAF_ST_RESOLVE = 4'h8
  } oaf_state_t;

endpackage

// >>> tb/oaf_mem_model.sv
`timescale 1ns/1ps
module oaf_mem_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:255];
  logic [7:0] last_reg;

  // Zero-wait read; an idle bus shows the inverse of the last byte
  always_comb mem_rdata = mem_rd ? mem[mem_addr[7:0]] : ~last_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_reg <= 8'h00;
    end else if (mem_rd) begin
      last_reg <= mem[mem_addr[7:0]];
    end
  end
endmodule // oaf_mem_model

// >>> tb/cpu_operand_address_former_test.sv
`timescale 1ns/1ps
module cpu_operand_address_former_test;
  localparam logic [15:0] PC = 16'h12F0;
  localparam logic [15:0] HX = 16'hFFF8;
  localparam logic [15:0] SP = 16'h0100;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [3:0] mode = 4'h0;
  logic is_compare_branch = 1'b0;
  logic is_move = 1'b0;
  logic branch_cond = 1'b0;
  logic carry_flag = 1'b0;
  logic [15:0] pc_in = 16'h0000;
  logic [15:0] hx_in = 16'h0000;
  logic [15:0] sp_in = 16'h0000;
  logic [7:0] mem_rdata;
  logic busy, mem_rd, pc_wr, hx_wr, sp_wr, illegal, done;
  logic [15:0] mem_addr, ea, operand, pc_out, hx_out, sp_out;
  logic [15:0] cyc;
  logic [15:0] fa [0:1];
  int nf;
  int n_fail = 0;
  int tests_run = 0;

  always #2.5 clk = ~clk;

  oaf_operand_address_former dut_u (.clk(clk), .resetn(resetn), .start(start), .opcode(opcode), .mode(mode),
    .is_compare_branch(is_compare_branch), .is_move(is_move), .branch_cond(branch_cond),
    .carry_flag(carry_flag), .pc_in(pc_in), .hx_in(hx_in), .sp_in(sp_in), .mem_rdata(mem_rdata),
    .busy(busy), .mem_rd(mem_rd), .mem_addr(mem_addr), .ea(ea), .operand(operand), .pc_out(pc_out),
    .pc_wr(pc_wr), .hx_out(hx_out), .hx_wr(hx_wr), .sp_out(sp_out), .sp_wr(sp_wr), .illegal(illegal),
    .done(done));

  oaf_mem_model mem_u (.clk(clk), .resetn(resetn), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata));

  task automatic report_and_stop();
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic m2(input logic [7:0] b0, input logic [7:0] b1);
    mem_u.mem[PC[7:0]] = b0;
    mem_u.mem[PC[7:0] + 8'h01] = b1;
  endtask

  // One request; returns in the done cycle with fetch addresses logged
  task automatic op(input logic [7:0] oc, input logic [3:0] md, input logic cb, input logic mv,
                    input logic bc, input logic cf);
    @(posedge clk);
    start <= 1'b1;
    opcode <= oc;
    mode <= md;
    is_compare_branch <= cb;
    is_move <= mv;
    branch_cond <= bc;
    carry_flag <= cf;
    pc_in <= PC;
    hx_in <= HX;
    sp_in <= SP;
    @(posedge clk);
    start <= 1'b0;
    cyc = 16'h0001;
    nf = 0;
    #1;
    chk({15'h0000, busy}, 16'h0001);
    while (done !== 1'b1 && cyc < 16'h000A) begin
      if (mem_rd === 1'b1 && nf < 2) begin
        fa[nf] = mem_addr;
        nf++;
      end
      @(posedge clk);
      #1;
      cyc++;
    end
    chk({14'h0000, busy, done}, 16'h0001);
  endtask

  task automatic t_branch();
    m2(8'hF0, 8'h00);
    op(8'h24, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(cyc, 16'h0003);
    chk(fa[0], PC);
    chk(nf[15:0], 16'h0001);
    chk(pc_out, PC + 16'h0001 + 16'hFFF0);
    chk({15'h0000, pc_wr}, 16'h0001);
    op(8'h24, 4'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    chk(pc_out, PC + 16'h0001);
    chk(cyc, 16'h0003);
    m2(8'h7F, 8'h00);
    op(8'h20, 4'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    chk(pc_out, PC + 16'h0080);
    op(8'h20, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(pc_out, PC + 16'h0001);
  endtask

  task automatic t_imm_dir();
    m2(8'hA5, 8'h3C);
    op(8'h20, 4'h1, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(ea, PC);
    chk(operand, 16'h00A5);
    op(8'h20, 4'h2, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(operand, 16'hA53C);
    chk(fa[1], PC + 16'h0001);
    chk(pc_out, PC + 16'h0002);
    m2(8'hC5, 8'h00);
    op(8'h20, 4'h3, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(ea, 16'h00C5);
    chk(cyc, 16'h0002);
    op(8'h20, 4'hB, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(ea, PC);
  endtask

  task automatic t_index();
    op(8'h20, 4'h4, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(ea, HX);
    chk(nf[15:0], 16'h0000);
    op(8'h20, 4'h5, 1'b0, 1'b1, 1'b0, 1'b0);
    chk(hx_out, HX + 16'h0001);
    chk({14'h0000, hx_wr, illegal}, 16'h0002);
    op(8'h20, 4'h5, 1'b0, 1'b0, 1'b0, 1'b0);
    chk({14'h0000, hx_wr, illegal}, 16'h0001);
    m2(8'hFF, 8'h00);
    op(8'h20, 4'h6, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(ea, 16'h00F7);
    chk(ea, HX + 16'h00FF);
    op(8'h20, 4'h7, 1'b1, 1'b0, 1'b0, 1'b0);
    chk({14'h0000, hx_wr, illegal}, 16'h0002);
    op(8'h20, 4'h7, 1'b0, 1'b1, 1'b0, 1'b0);
    chk({14'h0000, hx_wr, illegal}, 16'h0001);
    m2(8'hA5, 8'h3C);
    op(8'h20, 4'h8, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(ea, 16'hA534);
    chk(cyc, 16'h0003);
  endtask

  task automatic t_stack();
    m2(8'hFF, 8'h00);
    op(8'h20, 4'h9, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(ea, 16'h01FF);
    m2(8'hA5, 8'h3C);
    op(8'h20, 4'hA, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(ea, 16'hA63C);
    m2(8'h80, 8'h00);
    op(8'hA7, 4'h3, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(sp_out, 16'h0080);
    chk({14'h0000, sp_wr, hx_wr}, 16'h0002);
    chk(cyc, 16'h0002);
    op(8'hAF, 4'h3, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(hx_out, 16'hFF78);
    chk({14'h0000, hx_wr, sp_wr}, 16'h0002);
  endtask

  initial begin
    #10000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_branch();
    t_imm_dir();
    t_index();
    t_stack();
    report_and_stop();
  end
endmodule // cpu_operand_address_former_test
